// *** design/flash_prot_pkg.sv ***
package flash_prot_pkg;
  // Command cycles compare only the low address bits and the low data byte
  localparam int CMD_ADDR_BITS = 11;
  localparam int CMD_DATA_BITS = 8;
  localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
  localparam logic [10:0] UNLOCK_ADDR2 = 11'h2AA;
  localparam logic [10:0] ERASE_CONFIRM_ADDR = 11'h000;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PERSIST_ENTRY = 8'hC0;
  localparam logic [7:0] CMD_FREEZE_ENTRY = 8'h50;
  localparam logic [7:0] CMD_VOLATILE_ENTRY = 8'hE0;
  localparam logic [7:0] CMD_SETUP_ENTRY = 8'h40;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_SUMMARY = 8'h60;
  localparam logic [7:0] CMD_EXIT = 8'h90;
  localparam logic [7:0] CMD_EXIT_CONFIRM = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'h30;
  localparam logic [7:0] CMD_PROG_SUSPEND = 8'h51;
  localparam logic [7:0] CMD_PROG_RESUME = 8'h50;
  localparam logic [7:0] GUARD_SET_VALUE = 8'h00;
  localparam logic [7:0] GUARD_CLEAR_VALUE = 8'h01;
  // Sector decode
  localparam int UNIFORM_SECTOR_LSB = 17;
  localparam int PARAM_SECTOR_LSB = 11;
  localparam int PARAM_REGION_LSB = 14;
  localparam int PARAM_SECTOR_COUNT = 8;
  // Read word layout
  localparam logic [15:0] READ_ONES = 16'hFFFF;
  localparam int SUM_OVERALL_BIT = 0;
  localparam int SUM_VOLATILE_BIT = 1;
  localparam int SUM_PERSIST_BIT = 2;
  localparam int SETUP_PERSIST_LOCK_BIT = 1;
  localparam int SETUP_PASSWORD_LOCK_BIT = 2;
  // Reset values, 1 meaning erased or unprotected
  localparam logic [15:0] SETUP_RESET = 16'hFFFF;
  localparam logic GUARD_RESET = 1'b1;
  localparam logic FREEZE_RESET = 1'b1;

  typedef enum logic [2:0] {
    SPACE_ARRAY = 3'b000,
    SPACE_PERSIST = 3'b001,
    SPACE_FREEZE = 3'b010,
    SPACE_VOLATILE = 3'b011,
    SPACE_SETUP = 3'b100
  } space_e;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_UNLOCK1 = 3'b001,
    SEQ_UNLOCK2 = 3'b010,
    SEQ_PROGRAM = 3'b011,
    SEQ_ERASE = 3'b100,
    SEQ_EXIT = 3'b101,
    SEQ_SUMMARY = 3'b110
  } seq_e;
endpackage

// *** design/flash_sector_protection_cmds.sv ***
`timescale 1ns/1ps
module flash_sector_protection_cmds #(
  parameter int ADDR_W = 25
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire logic link_cs_n_in,
  input wire logic link_strobe_in,
  input wire logic link_we_in,
  input wire logic [ADDR_W-1:0] link_addr_in,
  input wire logic [15:0] link_data_in,
  input wire logic erase_active_in,
  input wire logic program_active_in,
  output logic link_ready_out,
  output logic [15:0] link_rdata_out,
  output logic link_rvalid_out,
  output logic [2:0] space_out,
  output logic freeze_bit_out,
  output logic [15:0] setup_out,
  output logic erase_suspended_out,
  output logic program_suspended_out
);
  localparam int UNI_W = ADDR_W - flash_prot_pkg::UNIFORM_SECTOR_LSB;
  localparam int NSEC = flash_prot_pkg::PARAM_SECTOR_COUNT + (1 << UNI_W);
  localparam int SEC_W = $clog2(NSEC);

  // Link domain
  logic link_rst_s1_reg;
  logic link_rst_s2_reg;
  logic [ADDR_W-1:0] link_hold_addr_reg;
  logic [15:0] link_hold_data_reg;
  logic link_hold_we_reg;
  logic link_req_tgl_reg;
  logic link_ack_s1_reg;
  logic link_ack_s2_reg;
  logic link_ack_s3_reg;
  // System domain
  logic req_s1_reg;
  logic req_s2_reg;
  logic req_s3_reg;
  logic ack_tgl_reg;
  logic [15:0] rdata_reg;
  flash_prot_pkg::space_e space_reg;
  flash_prot_pkg::seq_e seq_reg;
  logic [NSEC-1:0] persist_guard_bit_reg;
  logic [NSEC-1:0] volatile_guard_bit_reg;
  logic freeze_reg;
  logic [15:0] setup_reg;
  logic erase_susp_reg;
  logic prog_susp_reg;

  function automatic logic [SEC_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    logic [SEC_W-1:0] idx;
    idx = SEC_W'(flash_prot_pkg::PARAM_SECTOR_COUNT)
        + SEC_W'(a[ADDR_W-1:flash_prot_pkg::UNIFORM_SECTOR_LSB]);
    if (a[ADDR_W-1:flash_prot_pkg::PARAM_REGION_LSB] == '0) begin
      idx = SEC_W'(a[flash_prot_pkg::PARAM_REGION_LSB-1:flash_prot_pkg::PARAM_SECTOR_LSB]);
    end
    return idx;
  endfunction

  // Reset reaches the link side through two flops; host keeps its clock running then
  always_ff @(posedge link_clk_in) begin
    link_rst_s1_reg <= rst_n_in;
    link_rst_s2_reg <= link_rst_s1_reg;
  end

  // One bus cycle at a time; hold registers stay still until the answer returns
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_s2_reg) begin
      link_hold_addr_reg <= '0;
      link_hold_data_reg <= '0;
      link_hold_we_reg <= 1'b0;
      link_req_tgl_reg <= 1'b0;
    end else if (link_strobe_in && !link_cs_n_in && link_ready_out) begin
      link_hold_addr_reg <= link_addr_in;
      link_hold_data_reg <= link_data_in;
      link_hold_we_reg <= link_we_in;
      link_req_tgl_reg <= ~link_req_tgl_reg;
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_s2_reg) begin
      link_ack_s1_reg <= 1'b0;
      link_ack_s2_reg <= 1'b0;
      link_ack_s3_reg <= 1'b0;
    end else begin
      link_ack_s1_reg <= ack_tgl_reg;
      link_ack_s2_reg <= link_ack_s1_reg;
      link_ack_s3_reg <= link_ack_s2_reg;
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_s2_reg) begin
      link_ready_out <= 1'b1;
      link_rdata_out <= flash_prot_pkg::READ_ONES;
      link_rvalid_out <= 1'b0;
    end else begin
      link_rvalid_out <= 1'b0;
      if (link_strobe_in && !link_cs_n_in && link_ready_out) begin
        link_ready_out <= 1'b0;
      end else if (link_ack_s2_reg ^ link_ack_s3_reg) begin
        link_ready_out <= 1'b1;
        if (!link_hold_we_reg) begin
          // Each read cycle gets its answer word, flagged valid for one link clock
          link_rdata_out <= rdata_reg;
          link_rvalid_out <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
    end else begin
      req_s1_reg <= link_req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  logic evt;
  logic wr_evt;
  logic rd_evt;
  logic [flash_prot_pkg::CMD_ADDR_BITS-1:0] cmd_addr;
  logic [flash_prot_pkg::CMD_DATA_BITS-1:0] cmd_data;
  logic [SEC_W-1:0] req_sector;
  logic cur_persist;
  logic cur_volatile;
  logic [15:0] summary_word;
  logic [15:0] guard_word;
  logic f0_hit;

  assign evt = req_s2_reg ^ req_s3_reg;
  assign wr_evt = evt && link_hold_we_reg;
  assign rd_evt = evt && !link_hold_we_reg;
  assign cmd_addr = link_hold_addr_reg[flash_prot_pkg::CMD_ADDR_BITS-1:0];
  assign cmd_data = link_hold_data_reg[flash_prot_pkg::CMD_DATA_BITS-1:0];
  assign req_sector = sector_of(link_hold_addr_reg);
  assign cur_persist = persist_guard_bit_reg[req_sector];
  assign cur_volatile = volatile_guard_bit_reg[req_sector];
  assign f0_hit = (cmd_data == flash_prot_pkg::CMD_RESET) && (seq_reg != flash_prot_pkg::SEQ_PROGRAM);

  always_comb begin
    summary_word = flash_prot_pkg::READ_ONES;
    summary_word[flash_prot_pkg::SUM_OVERALL_BIT] = cur_persist & cur_volatile;
    summary_word[flash_prot_pkg::SUM_VOLATILE_BIT] = cur_volatile;
    summary_word[flash_prot_pkg::SUM_PERSIST_BIT] = cur_persist;
    guard_word = flash_prot_pkg::READ_ONES;
    if (space_reg == flash_prot_pkg::SPACE_PERSIST) begin
      guard_word[0] = cur_persist;
    end else if (space_reg == flash_prot_pkg::SPACE_VOLATILE) begin
      guard_word[0] = cur_volatile;
    end else if (space_reg == flash_prot_pkg::SPACE_FREEZE) begin
      guard_word[0] = freeze_reg;
    end
  end

  // Command sequencing
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      space_reg <= flash_prot_pkg::SPACE_ARRAY;
      seq_reg <= flash_prot_pkg::SEQ_IDLE;
    end else if (rd_evt && seq_reg == flash_prot_pkg::SEQ_SUMMARY) begin
      seq_reg <= flash_prot_pkg::SEQ_IDLE;
    end else if (wr_evt && f0_hit) begin
      space_reg <= flash_prot_pkg::SPACE_ARRAY;
      seq_reg <= flash_prot_pkg::SEQ_IDLE;
    end else if (wr_evt) begin
      seq_reg <= flash_prot_pkg::SEQ_IDLE;
      case (seq_reg)
        flash_prot_pkg::SEQ_IDLE: begin
          if (space_reg == flash_prot_pkg::SPACE_ARRAY) begin
            if (cmd_addr == flash_prot_pkg::UNLOCK_ADDR1 && cmd_data == flash_prot_pkg::CMD_UNLOCK1) begin
              seq_reg <= flash_prot_pkg::SEQ_UNLOCK1;
            end
          end else if (cmd_data == flash_prot_pkg::CMD_EXIT) begin
            seq_reg <= flash_prot_pkg::SEQ_EXIT;
          end else if (cmd_data == flash_prot_pkg::CMD_PROGRAM) begin
            seq_reg <= flash_prot_pkg::SEQ_PROGRAM;
          end else if (cmd_data == flash_prot_pkg::CMD_ERASE
                       && space_reg == flash_prot_pkg::SPACE_PERSIST) begin
            seq_reg <= flash_prot_pkg::SEQ_ERASE;
          end else if (cmd_data == flash_prot_pkg::CMD_SUMMARY
                       && (space_reg == flash_prot_pkg::SPACE_PERSIST
                           || space_reg == flash_prot_pkg::SPACE_VOLATILE)) begin
            seq_reg <= flash_prot_pkg::SEQ_SUMMARY;
          end
        end
        flash_prot_pkg::SEQ_UNLOCK1: begin
          if (cmd_addr == flash_prot_pkg::UNLOCK_ADDR2 && cmd_data == flash_prot_pkg::CMD_UNLOCK2) begin
            seq_reg <= flash_prot_pkg::SEQ_UNLOCK2;
          end
        end
        flash_prot_pkg::SEQ_UNLOCK2: begin
          if (cmd_addr == flash_prot_pkg::UNLOCK_ADDR1) begin
            case (cmd_data)
              flash_prot_pkg::CMD_PERSIST_ENTRY: space_reg <= flash_prot_pkg::SPACE_PERSIST;
              flash_prot_pkg::CMD_FREEZE_ENTRY: space_reg <= flash_prot_pkg::SPACE_FREEZE;
              flash_prot_pkg::CMD_VOLATILE_ENTRY: space_reg <= flash_prot_pkg::SPACE_VOLATILE;
              flash_prot_pkg::CMD_SETUP_ENTRY: space_reg <= flash_prot_pkg::SPACE_SETUP;
              default: space_reg <= space_reg;
            endcase
          end
        end
        flash_prot_pkg::SEQ_PROGRAM: begin
          if (space_reg == flash_prot_pkg::SPACE_SETUP
              && !link_hold_data_reg[flash_prot_pkg::SETUP_PERSIST_LOCK_BIT]
              && !link_hold_data_reg[flash_prot_pkg::SETUP_PASSWORD_LOCK_BIT]) begin
            space_reg <= flash_prot_pkg::SPACE_ARRAY;
          end
        end
        flash_prot_pkg::SEQ_EXIT: begin
          if (cmd_data == flash_prot_pkg::CMD_EXIT_CONFIRM) begin
            space_reg <= flash_prot_pkg::SPACE_ARRAY;
          end
        end
        default: seq_reg <= flash_prot_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Guard bits, freeze bit and setup register
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      persist_guard_bit_reg <= {NSEC{flash_prot_pkg::GUARD_RESET}};
      volatile_guard_bit_reg <= {NSEC{flash_prot_pkg::GUARD_RESET}};
      freeze_reg <= flash_prot_pkg::FREEZE_RESET;
      setup_reg <= flash_prot_pkg::SETUP_RESET;
    end else if (wr_evt && seq_reg == flash_prot_pkg::SEQ_PROGRAM) begin
      case (space_reg)
        flash_prot_pkg::SPACE_PERSIST: begin
          // A cleared freeze bit blocks all persistent changes until reset
          if (freeze_reg && cmd_data == flash_prot_pkg::GUARD_SET_VALUE) begin
            persist_guard_bit_reg[req_sector] <= 1'b0;
          end
        end
        flash_prot_pkg::SPACE_FREEZE: begin
          if (cmd_data == flash_prot_pkg::GUARD_SET_VALUE) begin
            freeze_reg <= 1'b0;
          end
        end
        flash_prot_pkg::SPACE_VOLATILE: begin
          if (cmd_data == flash_prot_pkg::GUARD_SET_VALUE) begin
            volatile_guard_bit_reg[req_sector] <= 1'b0;
          end else if (cmd_data == flash_prot_pkg::GUARD_CLEAR_VALUE) begin
            volatile_guard_bit_reg[req_sector] <= 1'b1;
          end
        end
        flash_prot_pkg::SPACE_SETUP: begin
          if (link_hold_data_reg[flash_prot_pkg::SETUP_PERSIST_LOCK_BIT]
              || link_hold_data_reg[flash_prot_pkg::SETUP_PASSWORD_LOCK_BIT]) begin
            setup_reg <= setup_reg & link_hold_data_reg;
          end
        end
        default: setup_reg <= setup_reg;
      endcase
    end else if (wr_evt && seq_reg == flash_prot_pkg::SEQ_ERASE && freeze_reg
                 && cmd_addr == flash_prot_pkg::ERASE_CONFIRM_ADDR
                 && cmd_data == flash_prot_pkg::CMD_ERASE_CONFIRM) begin
      persist_guard_bit_reg <= {NSEC{flash_prot_pkg::GUARD_RESET}};
    end
  end

  // Suspend and resume, single cycle writes while reading the array
  logic base_wr;
  assign base_wr = wr_evt && seq_reg == flash_prot_pkg::SEQ_IDLE
                   && space_reg == flash_prot_pkg::SPACE_ARRAY;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      erase_susp_reg <= 1'b0;
      prog_susp_reg <= 1'b0;
    end else if (base_wr) begin
      if (cmd_data == flash_prot_pkg::CMD_ERASE_SUSPEND && erase_active_in) begin
        erase_susp_reg <= 1'b1;
      end else if (cmd_data == flash_prot_pkg::CMD_ERASE_RESUME && erase_susp_reg) begin
        erase_susp_reg <= 1'b0;
      end else if (cmd_data == flash_prot_pkg::CMD_PROG_SUSPEND && program_active_in) begin
        prog_susp_reg <= 1'b1;
      end else if (cmd_data == flash_prot_pkg::CMD_PROG_RESUME && prog_susp_reg) begin
        prog_susp_reg <= 1'b0;
      end
    end
  end

  // Answer word; array data itself is served elsewhere
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata_reg <= flash_prot_pkg::READ_ONES;
      ack_tgl_reg <= 1'b0;
    end else if (evt) begin
      ack_tgl_reg <= ~ack_tgl_reg;
      if (rd_evt) begin
        if (seq_reg == flash_prot_pkg::SEQ_SUMMARY) begin
          rdata_reg <= summary_word;
        end else if (space_reg == flash_prot_pkg::SPACE_SETUP) begin
          rdata_reg <= setup_reg;
        end else begin
          rdata_reg <= guard_word;
        end
      end
    end
  end

  assign space_out = space_reg;
  assign freeze_bit_out = freeze_reg;
  assign setup_out = setup_reg;
  assign erase_suspended_out = erase_susp_reg;
  assign program_suspended_out = prog_susp_reg;

  property p_persist_entry;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_evt && seq_reg == flash_prot_pkg::SEQ_UNLOCK2 && cmd_addr == 11'h555 && cmd_data == 8'hC0
    |=> space_reg == flash_prot_pkg::SPACE_PERSIST;
  endproperty
  a_persist_entry: assert property (p_persist_entry) else $error("persistent entry missed");

  property p_freeze_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_evt && seq_reg == flash_prot_pkg::SEQ_PROGRAM && space_reg == flash_prot_pkg::SPACE_FREEZE
    && cmd_data == 8'h00 |=> !freeze_reg ##1 !freeze_reg;
  endproperty
  a_freeze_clear: assert property (p_freeze_clear) else $error("freeze bit not cleared");

  property p_volatile_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_evt && seq_reg == flash_prot_pkg::SEQ_PROGRAM && space_reg == flash_prot_pkg::SPACE_VOLATILE
    && cmd_data == 8'h01 |=> cur_volatile && seq_reg == flash_prot_pkg::SEQ_IDLE;
  endproperty
  a_volatile_clear: assert property (p_volatile_clear) else $error("volatile bit not cleared");

  property p_guard_read;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rd_evt && seq_reg == flash_prot_pkg::SEQ_IDLE && space_reg == flash_prot_pkg::SPACE_VOLATILE
    |=> rdata_reg == {15'h7FFF, $past(cur_volatile)};
  endproperty
  a_guard_read: assert property (p_guard_read) else $error("guard read word wrong");

  property p_summary_enter;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_evt && seq_reg == flash_prot_pkg::SEQ_IDLE && space_reg == flash_prot_pkg::SPACE_PERSIST
    && cmd_data == 8'h60 |=> seq_reg == flash_prot_pkg::SEQ_SUMMARY;
  endproperty
  a_summary_enter: assert property (p_summary_enter) else $error("summary not armed");

  property p_summary_word;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rd_evt && seq_reg == flash_prot_pkg::SEQ_SUMMARY
    |=> rdata_reg[15:4] == 12'hFFF && rdata_reg[0] == (rdata_reg[1] & rdata_reg[2]);
  endproperty
  a_summary_word: assert property (p_summary_word) else $error("summary word wrong");

  property p_exit;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_evt && seq_reg == flash_prot_pkg::SEQ_EXIT && cmd_data == 8'h00
    |=> space_reg == flash_prot_pkg::SPACE_ARRAY;
  endproperty
  a_exit: assert property (p_exit) else $error("exit did not return to array");

  property p_erase_suspend;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(erase_susp_reg) |-> $past(erase_active_in) && $past(base_wr);
  endproperty
  a_erase_suspend: assert property (p_erase_suspend) else $error("suspend without erase");

  property p_setup_abort;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_evt && seq_reg == flash_prot_pkg::SEQ_PROGRAM && space_reg == flash_prot_pkg::SPACE_SETUP
    && link_hold_data_reg[2:1] == 2'b00
    |=> space_reg == flash_prot_pkg::SPACE_ARRAY && setup_reg == $past(setup_reg);
  endproperty
  a_setup_abort: assert property (p_setup_abort) else $error("dual lock program not aborted");

  property p_abandon;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_evt && seq_reg == flash_prot_pkg::SEQ_UNLOCK1
    && !(cmd_addr == 11'h2AA && cmd_data == 8'h55) |=> seq_reg == flash_prot_pkg::SEQ_IDLE;
  endproperty
  a_abandon: assert property (p_abandon) else $error("bad unlock not abandoned");
endmodule

// *** test/link_host.sv ***
`timescale 1ns/1ps
module link_host (
  output logic link_clk_out,
  output logic link_cs_n_out,
  output logic link_strobe_out,
  output logic link_we_out,
  output logic [24:0] link_addr_out,
  output logic [15:0] link_data_out,
  input wire logic link_ready_in,
  input wire logic [15:0] link_rdata_in,
  input wire logic link_rvalid_in
);
  logic run = 1'b0;
  initial begin
    {link_clk_out, link_cs_n_out, link_strobe_out, link_we_out} = 4'b0100;
    {link_addr_out, link_data_out} = '0;
  end
  // Clock only runs while a cycle is in flight or the bench asks for idle edges
  always #32 link_clk_out = run ? ~link_clk_out : 1'b0;
  task automatic idle(input int n);
    run = 1'b1;
    repeat (n) @(posedge link_clk_out);
    run = 1'b0;
  endtask
  // One 16-bit word per cycle; writes for commands, reads only for answers
  // Never enters identity mode, buffer writes or key programming
  task automatic xfer(input logic w, input logic [24:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    int n;
    n = 0;
    run = 1'b1;
    @(posedge link_clk_out);
    #1;
    {link_cs_n_out, link_strobe_out, link_we_out, link_addr_out, link_data_out} = {2'b01, w, a, d};
    do @(posedge link_clk_out); while (link_ready_in !== 1'b1);
    #1;
    link_strobe_out = 1'b0;
    while (link_ready_in !== 1'b0 && n < 4) begin
      @(posedge link_clk_out);
      n++;
    end
    do begin
      @(posedge link_clk_out);
      n++;
    end while (!(link_ready_in === 1'b1 && (w || link_rvalid_in === 1'b1)) && n < 100);
    q = link_rdata_in;
    ok = n < 100;
    #1;
    // Released lines show the inverse so stale values are never mistaken for data
    {link_cs_n_out, link_addr_out, link_data_out} = {1'b1, ~a, ~d};
    run = 1'b0;
  endtask
endmodule

// *** test/flash_sector_protection_cmds_tb.sv ***
`timescale 1ns/1ps
`define CHK(what, exp, got) check(what, 16'(exp), 16'(got))
module flash_sector_protection_cmds_tb;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic erase_active_in = 1'b0;
  logic program_active_in = 1'b0;
  logic lclk, cs_n, stb, we, ready, rvalid, freeze, esus, psus, ok;
  logic [24:0] addr, a, b, o;
  logic [15:0] wdata, rdata, setup, q;
  logic [2:0] space;
  logic [7:0] s;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  link_host host (.link_clk_out(lclk), .link_cs_n_out(cs_n), .link_strobe_out(stb),
    .link_we_out(we), .link_addr_out(addr), .link_data_out(wdata), .link_ready_in(ready),
    .link_rdata_in(rdata), .link_rvalid_in(rvalid));
  flash_sector_protection_cmds #(.ADDR_W(25)) dut (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .link_clk_in(lclk), .link_cs_n_in(cs_n), .link_strobe_in(stb),
    .link_we_in(we), .link_addr_in(addr), .link_data_in(wdata),
    .erase_active_in(erase_active_in), .program_active_in(program_active_in),
    .link_ready_out(ready), .link_rdata_out(rdata), .link_rvalid_out(rvalid),
    .space_out(space), .freeze_bit_out(freeze), .setup_out(setup),
    .erase_suspended_out(esus), .program_suspended_out(psus));
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [24:0] wa, input logic [15:0] d);
    host.xfer(1'b1, wa, d, q, ok);
    if (!ok) begin
      fails++;
      $display("Error handshake expected 1 seen 0");
    end
  endtask
  task automatic rd(input logic [24:0] ra, input logic [15:0] e, input string nm);
    host.xfer(1'b0, ra, 16'($urandom), q, ok);
    `CHK(nm, e, ok ? q : ~e);
  endtask
  // Bits above the compared field are random since the device must ignore them
  task automatic cmd(input logic [10:0] ca, input logic [7:0] c);
    wr({14'($urandom), ca}, {8'($urandom), c});
  endtask
  task automatic enter(input logic [7:0] c);
    cmd(11'h555, 8'hAA);
    cmd(11'h2AA, 8'h55);
    cmd(11'h555, c);
  endtask
  task automatic exit_set();
    cmd(11'($urandom), 8'h90);
    cmd(11'($urandom), 8'h00);
  endtask
  function automatic logic [24:0] sec(input bit par, input logic [7:0] i, input logic [16:0] f);
    return par ? {11'h000, i[2:0], f[10:0]} : {i, f};
  endfunction
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ceiling is roughly ten times the expected run of about 95 link transfers
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h45EB1EAA));
    host.idle(6);
    @(negedge clk_sys_in) rst_n_in = 1'b1;
    host.idle(4);
    `CHK("space", 0, space);
    `CHK("setup", 16'hFFFF, setup);
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      s = k ? 8'($urandom_range(0, 6)) : 8'($urandom_range(1, 254));
      a = sec(k, s, 17'($urandom));
      b = sec(k, s, 17'($urandom));
      o = sec(k, s + 8'h01, 17'($urandom));
      enter(8'hE0);
      `CHK("space", 3, space);
      cmd(11'($urandom), 8'hA0);
      wr(a, 16'h0000);
      rd(b, 16'hFFFE, "volatile set");
      rd(o, 16'hFFFF, "neighbour");
      cmd(11'($urandom), 8'h60);
      rd(b, 16'hFFFC, "volatile summary");
      cmd(11'($urandom), 8'hA0);
      wr(b, 16'h0001);
      rd(a, 16'hFFFF, "volatile clear");
      exit_set();
      `CHK("space", 0, space);
      enter(8'hC0);
      `CHK("space", 1, space);
      cmd(11'($urandom), 8'hA0);
      wr(a, 16'h0000);
      rd(b, 16'hFFFE, "persistent set");
      cmd(11'($urandom), 8'h60);
      rd(b, 16'hFFFA, "persistent summary");
      cmd(11'($urandom), 8'h80);
      wr(25'h0000000, 16'h0030);
      rd(b, 16'hFFFF, "erase all");
      cmd(11'($urandom), 8'hF0);
      `CHK("space", 0, space);
      $display("test guard sector kind %0d done", k);
    end
    cmd(11'h555, 8'hAA);
    cmd(11'h2AA, 8'h55);
    cmd(11'h555, 8'hC1);
    `CHK("space", 0, space);
    cmd(11'h555, 8'hAA);
    cmd(11'h2AA, 8'h77);
    cmd(11'h555, 8'hC0);
    `CHK("space", 0, space);
    $display("test abandon done");
    enter(8'h50);
    `CHK("space", 2, space);
    rd(25'($urandom), 16'hFFFF, "freeze read");
    cmd(11'($urandom), 8'hA0);
    cmd(11'($urandom), 8'h00);
    `CHK("freeze", 0, freeze);
    rd(25'($urandom), 16'hFFFE, "freeze read");
    exit_set();
    enter(8'hC0);
    cmd(11'($urandom), 8'hA0);
    wr(a, 16'h0000);
    rd(a, 16'hFFFF, "frozen program");
    cmd(11'($urandom), 8'hF0);
    $display("test freeze done");
    enter(8'h40);
    cmd(11'($urandom), 8'hA0);
    wr(25'($urandom), 16'hFFF9);
    `CHK("space", 0, space);
    `CHK("setup", 16'hFFFF, setup);
    enter(8'h40);
    cmd(11'($urandom), 8'hA0);
    wr(25'($urandom), 16'hFFFD);
    cmd(11'($urandom), 8'hA0);
    wr(25'($urandom), 16'hFFFF);
    `CHK("setup", 16'hFFFD, setup);
    rd(25'($urandom), 16'hFFFD, "setup read");
    cmd(11'($urandom), 8'hF0);
    $display("test setup done");
    cmd(11'($urandom), 8'hB0);
    `CHK("erase suspend", 0, esus);
    @(negedge clk_sys_in) erase_active_in = 1'b1;
    cmd(11'($urandom), 8'h30);
    `CHK("erase suspend", 0, esus);
    cmd(11'($urandom), 8'hB0);
    `CHK("erase suspend", 1, esus);
    cmd(11'($urandom), 8'h30);
    `CHK("erase suspend", 0, esus);
    cmd(11'($urandom), 8'h50);
    `CHK("program suspend", 0, psus);
    @(negedge clk_sys_in) program_active_in = 1'b1;
    cmd(11'($urandom), 8'h51);
    `CHK("program suspend", 1, psus);
    cmd(11'($urandom), 8'h50);
    `CHK("program suspend", 0, psus);
    $display("test suspend done");
    print_verdict();
  end
endmodule
